// file: bench/opgs_ctrl_properties.sv
// port checks for the output phase and pin select block
module opgs_ctrl_props (
   // clock, reset, strobes and levels
   input logic        clk_i, nrst_i, reg_wr_i, reg_rd_i, p_level_i, n_level_i,
   // host port and modes
   input logic [15:0] reg_addr_i,
   input logic [7:0]  reg_wdata_i, reg_rdata_o,
   input logic [2:0]  p_mode_i, n_mode_i,
   // outputs
   input logic [3:0]  mirror_page_o,
   input logic [6:0]  mirror_offset_o,
   input logic [1:0]  out_p_o, out_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_rd_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("rdata moved");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 16'h0726
      |=> reg_rdata_o == 8'h00) else $error("unmapped read");
   a_ovr_rsvd: assert property (reg_rd_i && reg_addr_i == 16'h0724
      |=> reg_rdata_o[7:2] == 6'h00) else $error("override reserved");
   a_sel_rsvd: assert property (reg_rd_i && reg_addr_i >= 16'h0725
      && reg_addr_i <= 16'h0726 |=> !reg_rdata_o[7]) else $error("select reserved");
   // the select outputs lag the register by one cycle
   a_page_track: assert property (reg_wr_i && reg_addr_i == 16'h0725 ##1 !reg_wr_i
      |=> mirror_page_o == $past(reg_wdata_i[3:0], 2)) else $error("page");
   a_ofs_track: assert property (reg_wr_i && reg_addr_i == 16'h0726 ##1 !reg_wr_i
      |=> mirror_offset_o == $past(reg_wdata_i[6:0], 2)) else $error("offset");
   a_p_level: assert property (reg_wr_i && reg_addr_i == 16'h0724 && reg_wdata_i[0]
      ##1 !reg_wr_i && p_mode_i == 3'h1 |=> out_p_o == {2{$past(p_level_i)}}) else $error("p lvl");
   a_n_level: assert property (reg_wr_i && reg_addr_i == 16'h0724 && reg_wdata_i[1]
      ##1 !reg_wr_i && n_mode_i == 3'h1 |=> out_n_o == {2{$past(n_level_i)}}) else $error("n lvl");
endmodule
bind opgs_ctrl opgs_ctrl_props opgs_ctrl_props_i (
   .clk_i           (clk_i),
   .nrst_i          (nrst_i),
   .reg_wr_i        (reg_wr_i),
   .reg_rd_i        (reg_rd_i),
   .p_level_i       (p_level_i),
   .n_level_i       (n_level_i),
   .reg_addr_i      (reg_addr_i),
   .reg_wdata_i     (reg_wdata_i),
   .reg_rdata_o     (reg_rdata_o),
   .p_mode_i        (p_mode_i),
   .n_mode_i        (n_mode_i),
   .mirror_page_o   (mirror_page_o),
   .mirror_offset_o (mirror_offset_o),
   .out_p_o         (out_p_o),
   .out_n_o         (out_n_o)
);

// file: bench/tb_top.sv
// self-checking bench for the output phase and pin select block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0;
   logic        p_level_i = 0, n_level_i = 0, n_status_bit_i = 0;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [7:0]  reg_wdata_i = 8'h00, mirror_byte_i = 8'h00, reg_rdata_o;
   logic [2:0]  p_mode_i = 3'h0, n_mode_i = 3'h0;
   logic [1:0]  p_div_clk_i = 2'h0, n_div_clk_i = 2'h0, out_p_o, out_n_o;
   logic [3:0]  mirror_page_o;
   logic [6:0]  mirror_offset_o;
   int          n_errors = 0, check_count = 0, cyc = 0, d;
   opgs_ctrl opgs_ctrl_i (
      .clk_i           (clk_i),
      .nrst_i          (nrst_i),
      .reg_addr_i      (reg_addr_i),
      .reg_wr_i        (reg_wr_i),
      .reg_wdata_i     (reg_wdata_i),
      .reg_rd_i        (reg_rd_i),
      .reg_rdata_o     (reg_rdata_o),
      .p_div_clk_i     (p_div_clk_i),
      .n_div_clk_i     (n_div_clk_i),
      .p_mode_i        (p_mode_i),
      .n_mode_i        (n_mode_i),
      .p_level_i       (p_level_i),
      .n_level_i       (n_level_i),
      .mirror_byte_i   (mirror_byte_i),
      .n_status_bit_i  (n_status_bit_i),
      .mirror_page_o   (mirror_page_o),
      .mirror_offset_o (mirror_offset_o),
      .out_p_o         (out_p_o),
      .out_n_o         (out_n_o)
   );
   initial forever #25 clk_i = ~clk_i;
   // a hang counts as a mismatch; the run needs far fewer cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 4000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task step(int n = 1);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task chk(logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // strobes get a quiet cycle after them so no signal is set twice in one step
   task wr(logic [15:0] a, logic [7:0] v);
      reg_addr_i = a;
      reg_wdata_i = v;
      reg_wr_i = 1;
      step();
      reg_wr_i = 0;
      step();
   endtask
   task rd(logic [15:0] a, logic [7:0] e);
      reg_addr_i = a;
      reg_rd_i = 1;
      step();
      reg_rd_i = 0;
      chk(reg_rdata_o, e);
      step();
   endtask
   // one first-half pulse on both pins; count half cycles until it shows
   task meas(output int n);
      p_div_clk_i = 2'h1;
      n_div_clk_i = 2'h1;
      step();
      p_div_clk_i = 2'h0;
      n_div_clk_i = 2'h0;
      for (n = 0; out_p_o === 2'h0 && n < 200; n += 2) step();
      n += out_p_o[1];
      chk(out_n_o, out_p_o);
      step(40);
   endtask
   task t_reset();
      for (int a = 16'h0720; a < 16'h0727; a++) rd(16'(a), 8'h00);
      chk({mirror_page_o, mirror_offset_o}, 0);
      meas(d);
      chk(d, 18);
      $display("reset test done");
   endtask
   task t_phase();
      int ph[4];
      ph = '{1, -2, 5, -16};
      foreach (ph[i]) begin // negative entries move this output earlier
         for (int b = 0; b < 4; b++) wr(16'(16'h0720 + b), ph[i][31 - 8 * b -: 8]);
         meas(d);
         chk(d, 18 + ph[i]);
      end
      rd(16'h0720, 8'hFF);
      rd(16'h0723, 8'hF0);
      // the host leaves the offset at zero again, as N-pin divided formats need
      for (int b = 0; b < 4; b++) wr(16'(16'h0720 + b), 8'h00);
      meas(d);
      chk(d, 18);
      $display("phase test done");
   endtask
   task t_gpo();
      p_mode_i = 3'h1;
      n_mode_i = 3'h1;
      p_level_i = 1;
      wr(16'h0724, 8'hFF); // modes chosen before the override is set
      chk(out_p_o, 3);
      chk(out_n_o, 0);
      rd(16'h0724, 8'h03);
      wr(16'h0725, 8'hD3);
      wr(16'h0726, 8'h92);
      rd(16'h0725, 8'h53);
      rd(16'h0726, 8'h12);
      rd(16'h0727, 8'h00);
      chk(mirror_page_o, 3);
      chk(mirror_offset_o, 8'h12);
      p_mode_i = 3'h3;
      n_mode_i = 3'h3;
      n_status_bit_i = 1;
      mirror_byte_i = 8'h20;
      step(2);
      chk(out_p_o, 3);
      chk(out_n_o, 3);
      mirror_byte_i = 8'hDF;
      step(2);
      chk(out_p_o, 0);
      p_mode_i = 3'h1;
      n_mode_i = 3'h1;
      n_level_i = 1;
      wr(16'h0724, 8'h01);
      chk(out_n_o, 0);
      wr(16'h0724, 8'h02);
      chk(out_p_o, 0);
      chk(out_n_o, 3);
      $display("pin select test done");
   endtask
   // reset in mid-run brings a dirty state back to the defaults
   task t_rerst();
      nrst_i = 0;
      #1;
      chk({out_p_o, out_n_o, mirror_page_o, mirror_offset_o}, 0);
      step();
      nrst_i = 1;
      rd(16'h0720, 8'h00);
      rd(16'h0724, 8'h00);
      rd(16'h0725, 8'h00);
      meas(d);
      chk(d, 18);
      $display("mid-run reset test done");
   endtask
   task report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      step(3);
      nrst_i = 1;
      t_reset();
      t_phase();
      t_gpo();
      t_rerst();
      report_and_stop();
   end
endmodule

// file: inc/opgs_regs.vh
// register offsets, field positions and reset values of the output phase and pin select block
`ifndef OPGS_REGS_VH
`define OPGS_REGS_VH

// byte addresses in the host register map, most significant byte at the lowest address
`define OPGS_PHASE_B3      16'h0720
`define OPGS_PHASE_B2      16'h0721
`define OPGS_PHASE_B1      16'h0722
`define OPGS_PHASE_B0      16'h0723
`define OPGS_OVR_EN        16'h0724
`define OPGS_PSEL_HI       16'h0725
`define OPGS_PSEL_LO       16'h0726

// reset values
`define OPGS_PHASE_RST     32'h00000000
`define OPGS_OVR_EN_RST    2'h0
`define OPGS_PSEL_RST      16'h0000

// field positions
`define OPGS_OVR_P         0
`define OPGS_OVR_N         1
`define OPGS_OVR_MASK      8'h03
`define OPGS_PSEL_MASK     16'h7F7F
`define OPGS_BIT_HI        14
`define OPGS_BIT_LO        12
`define OPGS_PAGE_HI       11
`define OPGS_PAGE_LO       8
`define OPGS_OFS_HI        6
`define OPGS_OFS_LO        0

// general output mode codes
`define OPGS_MODE_LEVEL    3'h1
`define OPGS_MODE_STATUS   3'h3

`endif

// file: verilog/opgs_ctrl.v
// output phase offset and per-pin clock or general output selection for one output pair
`include "opgs_regs.vh"

// Behaviour
// - phase offset register is a 32-bit two's complement count of half synth cycles
// - positive offset delays output edges by that many half cycles, at most DEPTH - 2 - ADV (46), larger offsets clamp there
// - negative offset advances output edges by its magnitude in half cycles, at most ADV (16), larger magnitudes clamp there
// - override bit 0 clear: P pin carries divided clock, set: P general output mode
// - override bit 1 clear: N pin carries divided clock, set: N general output mode
// - status select bits 14:12 give bit position within the chosen byte
// - status select bits 11:8 give the host register map page
// - status select bits 6:0 give byte offset within the page
// - mode code 001 drives the pin with its general output value level
// - mode code 011 continuously mirrors the selected host register bit on P, and drives N from n_status_bit_i
module opgs_ctrl #(
   parameter DEPTH = 64,         // delay line length in half cycles
   parameter ADV   = 16          // base latency, the largest advance possible
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        nrst_i,
   // byte-wide host register port
   input  wire [15:0] reg_addr_i,
   input  wire        reg_wr_i,
   input  wire [7:0]  reg_wdata_i,
   input  wire        reg_rd_i,
   output reg  [7:0]  reg_rdata_o,
   // divided clocks, two half-cycle samples per cycle, [0] first half
   input  wire [1:0]  p_div_clk_i,
   input  wire [1:0]  n_div_clk_i,
   // general output configuration from neighbouring registers
   input  wire [2:0]  p_mode_i,
   input  wire [2:0]  n_mode_i,
   input  wire        p_level_i,
   input  wire        n_level_i,
   input  wire [7:0]  mirror_byte_i,
   input  wire        n_status_bit_i,
   // selected host register location for the P-pin mirror
   output reg  [3:0]  mirror_page_o,
   output reg  [6:0]  mirror_offset_o,
   // pins, two half-cycle levels per cycle, [0] first half
   output reg  [1:0]  out_p_o,
   output reg  [1:0]  out_n_o
);

   // tap limits held at the width of the tap so compares and clamps stay 32 bits
   localparam [31:0]  TAP_BASE = ADV;
   localparam [31:0]  TAP_MAX  = DEPTH - 2;

   // register storage
   reg  [31:0]        phase_r;
   reg  [1:0]         ovr_en_r;
   reg  [15:0]        psel_r;

   // half-cycle delay lines
   reg  [DEPTH-1:0]   p_hist_r;
   reg  [DEPTH-1:0]   n_hist_r;

   // combinational values
   reg  [1:0]         p_gpo_nxt;
   reg  [1:0]         n_gpo_nxt;
   reg  [31:0]        tap;
   reg  [7:0]         rdata_nxt;
   wire [31:0]        tap_early;
   wire [31:0]        neg_mag;
   wire [15:0]        psel_mask;
   wire [2:0]         sel_bit;

   // field taps of the status select register
   assign sel_bit = psel_r[`OPGS_BIT_HI:`OPGS_BIT_LO];

   // reserved bits 15 and 7 of the status select register never store a one
   assign psel_mask = `OPGS_PSEL_MASK;

   // size of a negative offset, the advance asked for
   assign neg_mag = ~phase_r + 32'h00000001;

   // first-half output sample sits one half cycle deeper in the line than the second half
   assign tap_early = tap + 32'h00000001;

   // register writes; reserved bits are masked on the way in
   // multibyte values change a byte at a time, so the pins may see mixed values mid-write
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phase_r  <= `OPGS_PHASE_RST;
         ovr_en_r <= `OPGS_OVR_EN_RST;
         psel_r   <= `OPGS_PSEL_RST;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `OPGS_PHASE_B3) begin
            phase_r[31:24] <= reg_wdata_i;
         end else if (reg_addr_i == `OPGS_PHASE_B2) begin
            phase_r[23:16] <= reg_wdata_i;
         end else if (reg_addr_i == `OPGS_PHASE_B1) begin
            phase_r[15:8] <= reg_wdata_i;
         end else if (reg_addr_i == `OPGS_PHASE_B0) begin
            phase_r[7:0] <= reg_wdata_i;
         end else if (reg_addr_i == `OPGS_OVR_EN) begin
            ovr_en_r <= reg_wdata_i[1:0];
         end else if (reg_addr_i == `OPGS_PSEL_HI) begin
            psel_r[15:8] <= reg_wdata_i & psel_mask[15:8];
         end else if (reg_addr_i == `OPGS_PSEL_LO) begin
            psel_r[7:0] <= reg_wdata_i & psel_mask[7:0];
         end
      end
   end

   // read mux; unmapped addresses read zero
   always @* begin
      rdata_nxt = 8'h00;
      if (reg_addr_i == `OPGS_PHASE_B3) begin
         rdata_nxt = phase_r[31:24];
      end else if (reg_addr_i == `OPGS_PHASE_B2) begin
         rdata_nxt = phase_r[23:16];
      end else if (reg_addr_i == `OPGS_PHASE_B1) begin
         rdata_nxt = phase_r[15:8];
      end else if (reg_addr_i == `OPGS_PHASE_B0) begin
         rdata_nxt = phase_r[7:0];
      end else if (reg_addr_i == `OPGS_OVR_EN) begin
         rdata_nxt = {6'h00, ovr_en_r};
      end else if (reg_addr_i == `OPGS_PSEL_HI) begin
         rdata_nxt = psel_r[15:8];
      end else if (reg_addr_i == `OPGS_PSEL_LO) begin
         rdata_nxt = psel_r[7:0];
      end
   end

   // read data register; holds until the next read strobe
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_nxt;
      end
   end

   // P half-cycle history: after a shift, bit 0 is the newest second-half sample
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         p_hist_r <= {DEPTH{1'b0}};
      end else begin
         p_hist_r <= {p_hist_r[DEPTH-3:0], p_div_clk_i[0], p_div_clk_i[1]};
      end
   end

   // N half-cycle history, same layout as the P line
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         n_hist_r <= {DEPTH{1'b0}};
      end else begin
         n_hist_r <= {n_hist_r[DEPTH-3:0], n_div_clk_i[0], n_div_clk_i[1]};
      end
   end

   // tap = base latency plus signed offset; an advance is a shorter delay than the base,
   // so offsets beyond the line are clamped rather than wrapped
   always @* begin
      tap = TAP_BASE + phase_r;
      if (phase_r[31] && (neg_mag > TAP_BASE)) begin
         tap = 32'h00000000;
      end else if (!phase_r[31] && (tap > TAP_MAX)) begin
         tap = TAP_MAX;
      end
   end

   // P general output level; reserved codes drive low so a bad code never leaks a clock
   always @* begin
      p_gpo_nxt = 2'h0;
      case (p_mode_i)
         `OPGS_MODE_LEVEL: p_gpo_nxt = {2{p_level_i}};
         `OPGS_MODE_STATUS: p_gpo_nxt = {2{mirror_byte_i[sel_bit]}};
         default: p_gpo_nxt = 2'h0;
      endcase
   end

   // N general output level; its bit select lives outside this block
   always @* begin
      n_gpo_nxt = 2'h0;
      case (n_mode_i)
         `OPGS_MODE_LEVEL: n_gpo_nxt = {2{n_level_i}};
         `OPGS_MODE_STATUS: n_gpo_nxt = {2{n_status_bit_i}};
         default: n_gpo_nxt = 2'h0;
      endcase
   end

   // mirror location, registered so the outside lookup sees settled fields
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mirror_page_o   <= 4'h0;
         mirror_offset_o <= 7'h00;
      end else begin
         mirror_page_o   <= psel_r[`OPGS_PAGE_HI:`OPGS_PAGE_LO];
         mirror_offset_o <= psel_r[`OPGS_OFS_HI:`OPGS_OFS_LO];
      end
   end

   // P pin driver; the override switches both half-cycle levels at once
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_p_o <= 2'h0;
      end else if (ovr_en_r[`OPGS_OVR_P]) begin
         out_p_o <= p_gpo_nxt;
      end else begin
         out_p_o <= {p_hist_r[tap], p_hist_r[tap_early]};
      end
   end

   // N pin driver; same tap as P, so the pair stays aligned
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_n_o <= 2'h0;
      end else if (ovr_en_r[`OPGS_OVR_N]) begin
         out_n_o <= n_gpo_nxt;
      end else begin
         out_n_o <= {n_hist_r[tap], n_hist_r[tap_early]};
      end
   end

endmodule
